// ---- logic/sabc_alarm.sv ----
// four trip level alarm, relay drive, bar colour and programming menu
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: all four levels are evaluated even without relays fitted
// RULE2: operator parks unused levels at 9999 or -1999 per sense
// RULE3: program plus increment enters the menu at level 1
// RULE4: make delay needs alarm held for whole delay before relay on
// RULE5: break delay needs non-alarm held for whole delay before relay off
// RULE6: only levels 1 and 3 have delays; 2 and 4 act at once
// RULE7: menu order levels, delays, deadbands, then sense digits
// RULE8: high sense trips above the level, low sense below it
// RULE9: four sense digits edited left to right for levels 1 to 4
// RULE10: selected sense digit flashes with dp; program steps on
// RULE11: after digit four, mono unit exits, tri-colour goes to base colour
// RULE12: bar shows exactly one colour for its zone
// RULE13: below the lowest level the base colour shows
// RULE14: above a level its colour shows regardless of level order
// RULE15: equal levels, highest numbered level colour wins
// RULE16: each colour is green, orange or red, cycled by up and down
// RULE17: colours go base, level 1 to 4, then exit
// RULE18: dim input halves brightness setting
// RULE19: lock input allows viewing but blocks every change
// RULE20: alarm clears only after reading returns past level by deadband
// RULE21: delays count one-second ticks and restart when interrupted
module sabc_alarm
  import sabc_pkg::*;
#(
  parameter longint TICK_CYCLES = TICK_CYC,
  parameter bit     TRI_COLOUR  = 1'b1
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // measurement
  input  wire logic signed [VAL_W-1:0] reading,
  input  wire logic                    readingValid,
  // front panel
  input  wire sabc_keys_s              keys,
  input  wire logic [1:0]              brightSet,
  // rear panel, active low when tied to common
  input  wire logic                    lock_n,
  input  wire logic                    dim_n,
  // relay and indicators
  output logic [NLVL-1:0]              relayOn,
  output logic [NLVL-1:0]              levelLed,
  output sabc_hue_e                    barHue,
  output logic [1:0]                   brightOut,
  // menu display
  output sabc_view_s                   view,
  output logic signed [VAL_W-1:0]      viewValue
);
  // ---------------------------------------------------------------
  // settings storage
  // ---------------------------------------------------------------
  logic signed [VAL_W-1:0] level [NLVL];
  logic signed [VAL_W-1:0] band  [NLVL];
  logic [DLY_W-1:0]        makeDelay  [2];
  logic [DLY_W-1:0]        breakDelay [2];
  logic [NLVL-1:0]         senseHigh;
  sabc_hue_e               baseHue;
  sabc_hue_e               hue [NLVL];
  logic [NLVL-1:0]         alarm;
  logic [NLVL-1:0]         relayNow;
  sabc_menu_e              menu, next_menu;
  logic [1:0]              idx, next_idx;
  logic                    tick;

  // ---------------------------------------------------------------
  // one-second tick
  // ---------------------------------------------------------------
  sabc_tick #(.CYC(TICK_CYCLES)) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // per level comparison with deadband, and relay timing
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NLVL; g++) begin : gLvl
      wire signed [VAL_W:0] lvlX   = (VAL_W+1)'(level[g]);
      wire signed [VAL_W:0] relLo  = lvlX - band[g];
      wire signed [VAL_W:0] relHi  = lvlX + band[g];
      wire signed [VAL_W:0] rdX    = (VAL_W+1)'(reading);
      wire                  tripHi = rdX > lvlX;
      wire                  tripLo = rdX < lvlX;
      wire                  clrHi  = rdX <= relLo;
      wire                  clrLo  = rdX >= relHi;
      wire                  setIt  = senseHigh[g] ? tripHi : tripLo;    // RULE8
      wire                  clrIt  = senseHigh[g] ? clrHi : clrLo;      // RULE20
      // alarm latch, evaluated for every level
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          alarm[g] <= 1'b0;
        end else if (readingValid) begin
          alarm[g] <= setIt | (alarm[g] & ~clrIt);                      // RULE1 RULE20
        end
      end
      if (g == 0 || g == 2) begin : gDly
        sabc_delay u_dly (
          .clk        (clk),
          .sys_rst    (sys_rst),
          .tick       (tick),
          .makeDelay  (makeDelay[g/2]),
          .breakDelay (breakDelay[g/2]),
          .alarm      (alarm[g]),
          .relay      (relayNow[g])
        );
      end else begin : gNoDly
        assign relayNow[g] = alarm[g];                                  // RULE6
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // bar colour: scan levels 1 to 4 so later ones override ties
  // ---------------------------------------------------------------
  sabc_hue_e               zoneHue;
  logic signed [VAL_W-1:0] zoneLvl;
  always_comb begin
    zoneHue = baseHue;                                                  // RULE13
    zoneLvl = READ_MIN;
    for (int i = 0; i < NLVL; i++) begin
      if (reading > level[i] && level[i] >= zoneLvl) begin
        zoneHue = hue[i];                                               // RULE14 RULE15
        zoneLvl = level[i];
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      relayOn   <= '0;
      levelLed  <= '0;
      barHue    <= HUE_GREEN;
      brightOut <= '0;
    end else begin
      relayOn   <= relayNow;
      levelLed  <= relayNow;                                            // RULE1
      barHue    <= TRI_COLOUR ? zoneHue : HUE_GREEN;                    // RULE12
      brightOut <= dim_n ? brightSet : (brightSet >> 1);                // RULE18
    end
  end

  // ---------------------------------------------------------------
  // menu sequencing
  // ---------------------------------------------------------------
  wire hasDelay = (idx == 2'd0) || (idx == 2'd2);                       // RULE6
  wire lastIdx  = (idx == 2'd3);
  wire editOk   = lock_n;                                               // RULE19
  wire enterKey = keys.prog & keys.up;
  wire stepKey  = keys.prog & ~keys.up;

  always_comb begin
    next_menu = menu;
    next_idx  = idx;
    case (menu)
      M_IDLE: if (enterKey) begin
        next_menu = M_LVL;                                              // RULE3
        next_idx  = 2'd0;
      end
      M_LVL: if (stepKey) next_menu = hasDelay ? M_MAKE : M_BAND;       // RULE7
      M_MAKE: if (stepKey) next_menu = M_BREAK;
      M_BREAK: if (stepKey) next_menu = M_BAND;
      M_BAND: if (stepKey) begin
        next_menu = lastIdx ? M_SENSE : M_LVL;
        next_idx  = idx + 2'd1;
      end
      M_SENSE: if (stepKey) begin
        next_idx = idx + 2'd1;                                          // RULE9 RULE10
        if (lastIdx) next_menu = TRI_COLOUR ? M_BASE : M_IDLE;          // RULE11
      end
      M_BASE: if (stepKey) begin
        next_menu = M_HUE;
        next_idx  = 2'd0;
      end
      M_HUE: if (stepKey) begin
        next_idx = idx + 2'd1;
        if (lastIdx) next_menu = M_IDLE;                                // RULE17
      end
      default: next_menu = M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      menu <= M_IDLE;
      idx  <= 2'd0;
    end else begin
      menu <= next_menu;
      idx  <= next_idx;
    end
  end

  // ---------------------------------------------------------------
  // value editing with up and down, limited to legal range
  // ---------------------------------------------------------------
  wire inc = keys.up & ~keys.prog & editOk;                             // RULE19
  wire dec = keys.down & ~keys.prog & editOk;

  function automatic logic signed [VAL_W-1:0] bump(
    input logic signed [VAL_W-1:0] v,
    input logic signed [VAL_W-1:0] lo,
    input logic signed [VAL_W-1:0] hi,
    input logic                    up,
    input logic                    dn
  );
    bump = v;
    if (up && v < hi) bump = v + 16'sh0001;
    if (dn && v > lo) bump = v - 16'sh0001;
  endfunction : bump

  function automatic sabc_hue_e cycle(input sabc_hue_e h, input logic up, input logic dn);
    cycle = h;
    if (up) cycle = (h == HUE_RED) ? HUE_GREEN : sabc_hue_e'(h + 2'd1);   // RULE16
    if (dn) cycle = (h == HUE_GREEN) ? HUE_RED : sabc_hue_e'(h - 2'd1);
  endfunction : cycle

  wire signed [VAL_W-1:0] mk = VAL_W'(makeDelay[idx[1]]);
  wire signed [VAL_W-1:0] bk = VAL_W'(breakDelay[idx[1]]);
  wire signed [VAL_W-1:0] dMax = VAL_W'(DLY_MAX);
  wire signed [VAL_W-1:0] zero = LEVEL_RST;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NLVL; i++) begin
        level[i] <= LEVEL_RST;
        band[i]  <= LEVEL_RST;
        hue[i]   <= sabc_hue_e'(HUE_RST);
      end
      for (int i = 0; i < 2; i++) begin
        makeDelay[i]  <= '0;
        breakDelay[i] <= '0;
      end
      senseHigh <= '1;
      baseHue   <= sabc_hue_e'(HUE_RST);
    end else begin
      case (menu)
        M_LVL:   level[idx] <= bump(level[idx], READ_MIN, READ_MAX, inc, dec);
        M_MAKE:  makeDelay[idx[1]]  <= DLY_W'(bump(mk, zero, dMax, inc, dec));  // RULE4
        M_BREAK: breakDelay[idx[1]] <= DLY_W'(bump(bk, zero, dMax, inc, dec));  // RULE5
        M_BAND:  band[idx] <= bump(band[idx], zero, BAND_MAX, inc, dec);
        M_SENSE: if (inc | dec) senseHigh[idx] <= ~senseHigh[idx];      // RULE9
        M_BASE:  baseHue <= cycle(baseHue, inc, dec);                    // RULE16
        M_HUE:   hue[idx] <= cycle(hue[idx], inc, dec);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // display of the current menu item
  // ---------------------------------------------------------------
  logic signed [VAL_W-1:0] next_viewValue;
  always_comb begin
    case (menu)
      M_LVL:   next_viewValue = level[idx];
      M_MAKE:  next_viewValue = mk;
      M_BREAK: next_viewValue = bk;
      M_BAND:  next_viewValue = band[idx];
      M_SENSE: next_viewValue = VAL_W'(senseHigh);
      M_BASE:  next_viewValue = VAL_W'(baseHue);
      M_HUE:   next_viewValue = VAL_W'(hue[idx]);
      default: next_viewValue = reading;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      view      <= '0;
      viewValue <= '0;
    end else begin
      view.active <= menu != M_IDLE;
      view.item   <= 4'(menu);
      view.lvl    <= idx;
      view.digit  <= idx;
      view.flash  <= menu == M_SENSE;                                   // RULE10
      viewValue   <= next_viewValue;
    end
  end
endmodule : sabc_alarm

// ---- logic/sabc_delay.sv ----
// make and break delay qualifier for one trip level
`timescale 1ns/10ps
module sabc_delay
  import sabc_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // timing
  input  wire logic             tick,
  input  wire logic [DLY_W-1:0] makeDelay,
  input  wire logic [DLY_W-1:0] breakDelay,
  // condition in, relay state out
  input  wire logic             alarm,
  output logic                  relay
);
  logic [DLY_W-1:0] secs;
  wire              differ   = alarm != relay;
  wire [DLY_W-1:0]  limit    = alarm ? makeDelay : breakDelay;
  // the first tick may come at once, so one extra tick guarantees the whole delay
  wire              expired  = (limit == '0) || (secs > limit);   // RULE4 RULE5

  // count whole seconds while the condition differs from the relay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      secs  <= '0;
      relay <= 1'b0;
    end else if (!differ) begin
      secs  <= '0;                      // RULE21
    end else if (expired) begin
      relay <= alarm;                   // RULE4 RULE5
      secs  <= '0;
    end else if (tick) begin
      secs  <= secs + 1'b1;             // RULE21
    end
  end
endmodule : sabc_delay

// ---- logic/sabc_pkg.sv ----
// shared constants and types for the trip level alarm and bar colour block
package sabc_pkg;
  // ---------------------------------------------------------------
  // widths and value limits
  // ---------------------------------------------------------------
  localparam int                  VAL_W       = 16;
  localparam int                  DLY_W       = 14;
  localparam int                  NLVL        = 4;
  localparam logic signed [15:0]  READ_MAX    = 16'sh270f;  // 9999
  localparam logic signed [15:0]  READ_MIN    = -16'sh07cf; // -1999
  localparam logic signed [15:0]  BAND_MAX    = 16'sh270f;
  localparam logic [13:0]         DLY_MAX     = 14'h270f;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ       = 25000000;
  localparam longint TICK_S       = 1;
  localparam longint TICK_CYC     = CLK_HZ * TICK_S;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic signed [15:0] LEVEL_RST = 16'sh0000;
  localparam logic [1:0]         HUE_RST   = 2'h0;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {HUE_GREEN, HUE_ORANGE, HUE_RED} sabc_hue_e;
  typedef enum {
    M_IDLE, M_LVL, M_MAKE, M_BREAK, M_BAND, M_SENSE, M_BASE, M_HUE
  } sabc_menu_e;
  // front panel buttons, one-cycle pulses
  typedef struct packed {
    logic prog;
    logic up;
    logic down;
  } sabc_keys_s;
  // what the menu puts on the display
  typedef struct packed {
    logic       active;
    logic [3:0] item;     // menu step number
    logic [1:0] lvl;      // level being edited
    logic [1:0] digit;    // sense digit being edited
    logic       flash;    // selected digit flashes, dp lit
  } sabc_view_s;
endpackage : sabc_pkg

// ---- logic/sabc_tick.sv ----
// one-second tick generator
`timescale 1ns/10ps
module sabc_tick
  import sabc_pkg::*;
#(
  parameter longint CYC = TICK_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // tick out
  output logic      tick
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;
  wire           wrap = (cnt == CW'(CYC - 1));

  // free running divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? '0 : cnt + 1'b1;
      tick <= wrap; // RULE21
    end
  end
endmodule : sabc_tick

// ---- verif/sabc_alarm_chk.sv ----
// port-level assertions for the trip level alarm block
`timescale 1ns/10ps
module sabc_alarm_chk
  import sabc_pkg::*;
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // inputs watched
  input wire logic                    readingValid,
  input wire sabc_keys_s              keys,
  input wire logic [1:0]              brightSet,
  input wire logic                    lock_n,
  input wire logic                    dim_n,
  // outputs watched
  input wire logic [NLVL-1:0]         relayOn,
  input wire logic [NLVL-1:0]         levelLed,
  input wire sabc_hue_e               barHue,
  input wire logic [1:0]              brightOut,
  input wire sabc_view_s              view,
  input wire logic signed [VAL_W-1:0] viewValue
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // brightness follows setting, halved while dimmed
  a_dim_half: assert property (1'b1 |=> brightOut ==
    ($past(dim_n) ? $past(brightSet) : ($past(brightSet) >> 1)))
    else $error("brightness output wrong");
  // indicators mirror relay drive for all four levels
  a_led_match: assert property (levelLed == relayOn)
    else $error("level indicator differs from relay");
  // only the three legal colours
  a_hue_legal: assert property (barHue inside {HUE_GREEN, HUE_ORANGE, HUE_RED})
    else $error("illegal bar colour");
  // program plus up opens the menu at level one
  a_menu_enter: assert property (!view.active && keys.prog && keys.up |-> ##2
    (view.active && view.item == 4'h1 && view.lvl == 2'h0))
    else $error("menu entry wrong");
  // sense digit being edited flashes
  a_sense_flash: assert property (view.item == 4'h5 |-> view.flash)
    else $error("sense digit not flashing");
  // level two goes straight to its deadband
  a_band_step: assert property (view.item == 4'h1 && view.lvl == 2'h1 &&
    keys == 3'b100 |-> ##2 view.item == 4'h4)
    else $error("level two step wrong");
  // locked in the menu: shown value never changes unless the item does
  a_lock_hold: assert property ((!lock_n [*3] ##0 (view.active && $stable(view)))
    |-> $stable(viewValue))
    else $error("value changed while locked");
  // undelayed relays move two cycles after a reading
  a_fast_relay: assert property ($changed(relayOn[1]) || $changed(relayOn[3])
    |-> $past(readingValid, 2))
    else $error("undelayed relay moved without reading");
endmodule : sabc_alarm_chk

bind sabc_alarm sabc_alarm_chk i_sabc_alarm_chk (
  .clk(clk), .sys_rst(sys_rst), .readingValid(readingValid), .keys(keys),
  .brightSet(brightSet), .lock_n(lock_n), .dim_n(dim_n), .relayOn(relayOn),
  .levelLed(levelLed), .barHue(barHue), .brightOut(brightOut), .view(view),
  .viewValue(viewValue)
);

// ---- verif/sabc_panel.sv ----
// front panel operator model issuing one-cycle button pulses
`timescale 1ns/10ps
module sabc_panel
  import sabc_pkg::*;
(
  // clock
  input  wire logic clk,
  // buttons out
  output sabc_keys_s keys
);
  initial keys = '0;
  // one pulse launched just after an edge, held one whole cycle
  task automatic press(input logic [2:0] k);
    @(posedge clk);
    #1 keys = k;
    @(posedge clk);
    #1 keys = '0;
  endtask : press
endmodule : sabc_panel

// ---- verif/tb.sv ----
// self-checking bench for the trip level alarm block
`timescale 1ns/10ps
module tb
  import sabc_pkg::*;
;
  logic                    clk          = 1'b0;
  logic                    sys_rst      = 1'b1;
  logic signed [VAL_W-1:0] reading;
  logic                    readingValid;
  logic [1:0]              brightSet;
  logic                    lock_n;
  logic                    dim_n;
  sabc_keys_s              keys;
  logic [NLVL-1:0]         relayOn;
  logic [NLVL-1:0]         levelLed;
  sabc_hue_e               barHue;
  logic [1:0]              brightOut;
  sabc_view_s              view;
  logic signed [VAL_W-1:0] viewValue;
  int                      err_total = 0;
  int                      n_checks  = 0;
  int                      cycles    = 0;
  // menu walk: item expected and up presses given at each step
  int stepItem [21] = '{1, 2, 3, 4, 1, 4, 1, 2, 3, 4, 1, 4, 5, 5, 5, 5, 6, 7, 7, 7, 7};
  int stepUps  [21] = '{2, 2, 2, 1, 4, 0, 4, 0, 0, 0, 6, 0, 0, 0, 0, 1, 1, 2, 0, 1, 2};
  // table: reading, relays 4..2, colour
  int rdRow  [6] = '{1, 3, 5, 7, 4, 6};
  int relRow [6] = '{4, 4, 7, 3, 4, 3};
  int hueRow [6] = '{1, 2, 1, 2, 2, 1};

  always #20 clk = ~clk;

  sabc_alarm #(.TICK_CYCLES(10), .TRI_COLOUR(1'b1)) i_sabc_alarm (
    .clk(clk), .sys_rst(sys_rst), .reading(reading), .readingValid(readingValid),
    .keys(keys), .brightSet(brightSet), .lock_n(lock_n), .dim_n(dim_n),
    .relayOn(relayOn), .levelLed(levelLed), .barHue(barHue), .brightOut(brightOut),
    .view(view), .viewValue(viewValue)
  );
  sabc_panel i_sabc_panel (.clk(clk), .keys(keys));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic sample(input int r);
    reading = r;
    readingValid = 1'b1;
    cyc(1);
    readingValid = 1'b0;
  endtask : sample

  task automatic close_out();
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reading      = '0;
    readingValid = 1'b0;
    brightSet    = 2'h3;
    lock_n       = 1'b1;
    dim_n        = 1'b1;
    cyc(10);
    sys_rst = 1'b0;
    cmp(relayOn, 4'h0);
    cmp(barHue, HUE_GREEN);
    cmp(view, '0);
    dim_n = 1'b0;
    brightSet = 2'h2;
    cyc(2);
    cmp(brightOut, 2'h1);
    dim_n = 1'b1;
    cyc(2);
    cmp(brightOut, 2'h2);
    // levels 2,4,4,6; level 1 delays 2 s, band 1; level 4 low sense
    i_sabc_panel.press(3'b110);
    cyc(2);
    for (int k = 0; k < 21; k++) begin
      cmp(view.item, stepItem[k]);
      if (stepItem[k] == 5) cmp(view.digit, k - 12);
      repeat (stepUps[k]) i_sabc_panel.press(3'b010);
      cyc(2);
      if (stepItem[k] < 5) cmp(viewValue, stepUps[k]);
      i_sabc_panel.press(3'b100);
      cyc(2);
    end
    cmp(view.active, 1'b0);
    // zones, ties and senses for levels 2 to 4
    for (int r = 0; r < 6; r++) begin
      sample(rdRow[r]);
      cyc(3);
      cmp(relayOn[3:1], relRow[r]);
      cmp(barHue, hueRow[r]);
    end
    // level one make, restart, deadband and break
    sample(0);
    cyc(30);
    cmp(relayOn[0], 1'b0);
    sample(3);
    cyc(8);
    cmp(relayOn[0], 1'b0);
    sample(0);
    cyc(2);
    sample(3);
    cyc(8);
    cmp(relayOn[0], 1'b0);
    cyc(10);
    cmp(relayOn[0], 1'b0);
    cyc(10);
    cmp(relayOn[0], 1'b1);
    sample(2);
    cyc(30);
    cmp(relayOn[0], 1'b1);
    sample(1);
    cyc(8);
    cmp(relayOn[0], 1'b1);
    cyc(10);
    cmp(relayOn[0], 1'b1);
    cyc(12);
    cmp(relayOn[0], 1'b0);
    // locked: view and step through, nothing changes
    lock_n = 1'b0;
    i_sabc_panel.press(3'b110);
    cyc(2);
    repeat (3) i_sabc_panel.press(3'b010);
    cyc(2);
    cmp(viewValue, 16'h0002);
    repeat (21) i_sabc_panel.press(3'b100);
    cyc(2);
    cmp(view.active, 1'b0);
    lock_n = 1'b1;
    // operator parks low-sense level 4 at the bottom of the range
    i_sabc_panel.press(3'b110);
    repeat (10) i_sabc_panel.press(3'b100);
    repeat (2010) i_sabc_panel.press(3'b001);
    cyc(2);
    cmp(viewValue, 16'hf831);
    repeat (11) i_sabc_panel.press(3'b100);
    cyc(2);
    sample(-1999);
    cyc(3);
    cmp(relayOn[3], 1'b0);
    cmp(barHue, HUE_ORANGE);
    close_out();
  end
endmodule : tb
